//--- rtl/ufd_pkg.sv
// constants for the user glyph memory and display-test block
// assumes a decoded register command port from the serial front end
package ufd_pkg;
	// register addresses and command codes
	localparam logic [7:0] UFD_ADDR_GLYPH   = 8'h05;
	localparam logic [7:0] UFD_ADDR_TEST    = 8'h07;
	localparam logic [7:0] UFD_CMD_GLYPH_RD = 8'h85;
	// glyph pointer map
	localparam logic [7:0] UFD_PTR_FIRST    = 8'h80;
	localparam logic [7:0] UFD_PTR_LAST     = 8'hF7;
	localparam logic [7:0] UFD_PTR_BAD_LO   = 8'hF8;
	localparam logic [7:0] UFD_GLYPH_LAST   = 8'hF3;
	localparam int         UFD_GLYPHS       = 24;
	localparam int         UFD_COLS         = 5;
	localparam int         UFD_ENTRIES      = UFD_GLYPHS * UFD_COLS;
	localparam int         UFD_COL_W        = 7;
	localparam int         UFD_PTR_DATA_BIT = 7;
	localparam int         UFD_TEST_BIT     = 0;
	// reset values
	localparam logic [7:0] UFD_PTR_RST      = 8'h80;
	localparam logic       UFD_TEST_RST     = 1'b0;
	// scan timing, counted in oscillator ticks
	localparam int         UFD_OSC_NOM_HZ   = 4000000;
	localparam int         UFD_SLOT_NS      = 100000;
	localparam int         UFD_SLOT_TICKS   = UFD_OSC_NOM_HZ / 1000 * UFD_SLOT_NS / 1000000;
	localparam int         UFD_TEST_SLOTS   = 8;
	localparam int         UFD_DUTY_NUM     = 7;
	localparam int         UFD_DUTY_DEN     = 16;
	localparam int         UFD_ON_TICKS     = UFD_SLOT_TICKS * UFD_DUTY_NUM / UFD_DUTY_DEN;
	// blink half-periods: 1 Hz and 0.5 Hz at nominal oscillator
	localparam int         UFD_BLINK_FAST_HALF = UFD_OSC_NOM_HZ / 2;
	localparam int         UFD_BLINK_SLOW_HALF = UFD_OSC_NOM_HZ;
endpackage : ufd_pkg

//--- rtl/ufd_glyph_test.sv
// user glyph memory, glyph pointer, display-test override and scan/blink timing
// assumes the serial front end presents each register access as a one-cycle command
module ufd_glyph_test
	import ufd_pkg::*;
#(
	parameter int BLINK_FAST_HALF = UFD_BLINK_FAST_HALF,
	parameter int BLINK_SLOW_HALF = UFD_BLINK_SLOW_HALF,
	parameter int SLOT_TICKS      = UFD_SLOT_TICKS,
	parameter int ON_TICKS        = UFD_ON_TICKS
) (
	// clock and reset
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	// register command port
	input  wire logic                 cmd_valid_i,
	input  wire logic [7:0]           cmd_addr_i,
	input  wire logic [7:0]           cmd_data_i,
	output logic                      rd_valid_o,
	output logic [7:0]                rd_data_o,
	// multiplex oscillator and blink
	input  wire logic                 mux_osc_input,
	input  wire logic                 blink_fast_i,
	output logic                      blink_o,
	// normal display path and glyph lookup
	input  wire logic [6:0]           glyph_raddr_i,
	output logic [UFD_COL_W-1:0]      glyph_rdata_o,
	input  wire logic [6:0]           norm_row_i,
	input  wire logic [7:0]           norm_digit_i,
	// drivers and status
	output logic [6:0]                row_o,
	output logic [7:0]                digit_o,
	output logic                      test_mode_o,
	output logic [7:0]                glyph_ptr_o
);
	logic [UFD_COL_W-1:0] glyph_mem [UFD_ENTRIES];
	logic [7:0]           ptr_r;
	logic [7:0]           ptr_nxt;
	logic                 test_r;
	logic                 osc_d_r;
	logic [15:0]          slot_cnt_r;
	logic [2:0]           slot_r;
	logic [23:0]          blink_cnt_r;
	logic                 blink_r;
	logic                 glyph_wr;
	logic                 glyph_rd;
	logic                 test_wr;
	logic                 ptr_load;
	logic                 col_wr;
	logic                 data_acc;
	logic                 ptr_step;
	logic [6:0]           mem_idx;
	logic                 ptr_at_end;
	logic                 load_bad;
	logic [7:0]           ptr_loaded;
	logic [7:0]           ptr_inc;
	logic                 osc_tick;
	logic                 slot_end;
	logic [23:0]          blink_half;
	logic                 blink_end;
	logic                 test_on;
	logic [7:0]           slot_hot;
	logic [6:0]           test_row;
	logic [7:0]           test_digit;
	logic [6:0]           row_nxt;
	logic [7:0]           digit_nxt;
	logic                 raddr_ok;
	logic [UFD_COL_W-1:0] lookup_nxt;

	// command decode; codes compared in full, so unknown ones do nothing
	assign glyph_wr   = cmd_valid_i && (cmd_addr_i == UFD_ADDR_GLYPH);
	assign glyph_rd   = cmd_valid_i && (cmd_addr_i == UFD_CMD_GLYPH_RD);
	assign test_wr    = cmd_valid_i && (cmd_addr_i == UFD_ADDR_TEST);
	assign ptr_load   = glyph_wr && cmd_data_i[UFD_PTR_DATA_BIT];
	assign col_wr     = glyph_wr && !cmd_data_i[UFD_PTR_DATA_BIT];
	assign data_acc   = col_wr || glyph_rd;
	assign ptr_step   = ptr_load || data_acc;
	assign mem_idx    = 7'(ptr_r - UFD_PTR_FIRST);

	// pointer next value
	assign ptr_at_end = (ptr_r == UFD_PTR_LAST);
	assign load_bad   = (cmd_data_i >= UFD_PTR_BAD_LO);
	// an out-of-range load falls back to the first glyph, never past memory
	assign ptr_loaded = load_bad ? UFD_PTR_FIRST : cmd_data_i;
	assign ptr_inc    = ptr_at_end ? UFD_PTR_FIRST : 8'(ptr_r + 8'h01);
	assign ptr_nxt    = ptr_load ? ptr_loaded : ptr_inc;

	// oscillator tick, inputs already synchronous
	assign osc_tick   = mux_osc_input && !osc_d_r;
	assign slot_end   = osc_tick && (slot_cnt_r == 16'(SLOT_TICKS - 1));
	assign blink_half = blink_fast_i ? 24'(BLINK_FAST_HALF - 1) :
	                                   24'(BLINK_SLOW_HALF - 1);
	// >= so a rate change mid-phase with the count past the new half ends that phase at the next oscillator tick
	assign blink_end  = osc_tick && (blink_cnt_r >= blink_half);
	assign test_on    = (slot_cnt_r < 16'(ON_TICKS));

	// one digit enable per scan slot
	for (genvar g = 0; g < 8; g++) begin : g_slot
		assign slot_hot[g] = (slot_r == 3'(g));
	end

	// display test overrides only the output mux, so stored state is kept
	assign test_row   = test_on ? 7'h7F : 7'h00;
	assign test_digit = test_on ? slot_hot : 8'h00;
	assign row_nxt    = test_r ? test_row : norm_row_i;
	assign digit_nxt  = test_r ? test_digit : norm_digit_i;

	// lookup past the last entry reads as blank
	assign raddr_ok   = (glyph_raddr_i < 7'(UFD_ENTRIES));
	assign lookup_nxt = raddr_ok ? glyph_mem[glyph_raddr_i] : '0;

	// glyph pointer
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_r <= UFD_PTR_RST;
		end else if (ptr_step) begin
			ptr_r <= ptr_nxt;
		end
	end

	// display-test bit; only D0 is kept
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			test_r <= UFD_TEST_RST;
		end else if (test_wr) begin
			test_r <= cmd_data_i[UFD_TEST_BIT];
		end
	end

	// glyph storage; no reset, contents survive test mode and reset
	always_ff @(posedge clock_i) begin
		if (col_wr) begin
			glyph_mem[mem_idx] <= cmd_data_i[UFD_COL_W-1:0];
		end
	end

	// host readback
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= 8'h00;
		end else begin
			rd_valid_o <= glyph_rd;
			if (glyph_rd) begin
				rd_data_o <= {1'b0, glyph_mem[mem_idx]};
			end
		end
	end

	// display lookup, one cycle of latency
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			glyph_rdata_o <= '0;
		end else begin
			glyph_rdata_o <= lookup_nxt;
		end
	end

	// scan slot timing; runs in normal mode too, so test may start mid-frame
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_d_r    <= 1'b0;
			slot_cnt_r <= 16'h0000;
			slot_r     <= 3'h0;
		end else begin
			osc_d_r <= mux_osc_input;
			if (slot_end) begin
				slot_cnt_r <= 16'h0000;
				slot_r     <= 3'(slot_r + 3'h1);
			end else if (osc_tick) begin
				slot_cnt_r <= 16'(slot_cnt_r + 16'h0001);
			end
		end
	end

	// blink phase: high in P0, low in P1
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			blink_cnt_r <= 24'h000000;
			blink_r     <= 1'b1;
		end else if (blink_end) begin
			blink_cnt_r <= 24'h000000;
			blink_r     <= !blink_r;
		end else if (osc_tick) begin
			blink_cnt_r <= 24'(blink_cnt_r + 24'h000001);
		end
	end

	// status copies
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			test_mode_o <= 1'b0;
			blink_o     <= 1'b1;
			glyph_ptr_o <= UFD_PTR_RST;
		end else begin
			test_mode_o <= test_r;
			blink_o     <= blink_r;
			glyph_ptr_o <= ptr_r;
		end
	end

	// row and digit drivers
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			row_o   <= 7'h00;
			digit_o <= 8'h00;
		end else begin
			row_o   <= row_nxt;
			digit_o <= digit_nxt;
		end
	end
endmodule : ufd_glyph_test

//--- bench/ufd_glyph_test_monitor.sv
// assertions on the glyph memory and display-test block
// bound to ufd_glyph_test; sees only its ports
module ufd_glyph_test_monitor (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	// command port
	input wire logic       cmd_valid_i,
	input wire logic [7:0] cmd_addr_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic       rd_valid_o,
	input wire logic [7:0] rd_data_o,
	// status
	input wire logic       test_mode_o,
	input wire logic [7:0] glyph_ptr_o,
	// drivers and normal path
	input wire logic [7:0] digit_o,
	input wire logic [7:0] norm_digit_i,
	input wire logic [6:0] row_o,
	input wire logic [6:0] norm_row_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence glyph_wr; cmd_valid_i && cmd_addr_i == 8'h05; endsequence
	sequence glyph_rd; cmd_valid_i && cmd_addr_i == 8'h85; endsequence
	rd_pulse_a: assert property (glyph_rd |=> rd_valid_o && !rd_data_o[7])
		else $error("read answer missing or msb set");
	rd_cause_a: assert property (rd_valid_o |-> $past(cmd_valid_i && cmd_addr_i == 8'h85))
		else $error("read answer without read command");
	ptr_load_a: assert property (glyph_wr ##0 cmd_data_i[7] && cmd_data_i < 8'hF8
		|=> ##1 glyph_ptr_o == $past(cmd_data_i, 2)) else $error("pointer not loaded");
	ptr_bad_a: assert property (glyph_wr ##0 cmd_data_i >= 8'hF8
		|=> ##1 glyph_ptr_o == 8'h80) else $error("bad pointer not forced to first");
	// old pointer is visible one cycle after the taking edge, so no gap is needed
	ptr_step_a: assert property ((glyph_wr ##0 !cmd_data_i[7]) or glyph_rd |=> ##1
		glyph_ptr_o == ($past(glyph_ptr_o) == 8'hF7 ? 8'h80 : $past(glyph_ptr_o) + 8'h01))
		else $error("pointer step wrong");
	test_set_a: assert property (cmd_valid_i && cmd_addr_i == 8'h07
		|=> ##1 test_mode_o == $past(cmd_data_i[0], 2)) else $error("test bit wrong");
	test_lit_a: assert property (test_mode_o |-> (row_o == 7'h7F && $onehot(digit_o))
		|| (row_o == 7'h00 && digit_o == 8'h00)) else $error("test pattern wrong");
	norm_pass_a: assert property (!test_mode_o |-> row_o == $past(norm_row_i)
		&& digit_o == $past(norm_digit_i)) else $error("normal path not followed");
endmodule : ufd_glyph_test_monitor
bind ufd_glyph_test ufd_glyph_test_monitor mon (.clock_i, .rst_n_i, .cmd_valid_i, .rd_valid_o,
	.test_mode_o, .cmd_addr_i, .cmd_data_i, .rd_data_o, .glyph_ptr_o, .digit_o, .norm_digit_i,
	.row_o, .norm_row_i);

//--- bench/ufd_host.sv
// host side of the register command port, one access per call
// drives after the falling edge; the block samples at the rising edge
module ufd_host (
	input  wire logic  clock_i,
	output logic       cmd_valid_o,
	output logic [7:0] cmd_addr_o,
	output logic [7:0] cmd_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid_o = 1'b0;
		cmd_addr_o = 8'h00;
		cmd_data_o = 8'h00;
	end
	// a base address sent as data to the glyph register starts a load
	task automatic acc(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i);
		cmd_valid_o = 1'b1;
		cmd_addr_o = a;
		cmd_data_o = d;
	endtask : acc
	// released data lines carry inverted values so stale data never matches; the address is left as it was
	task automatic idle();
		@(negedge clock_i);
		cmd_valid_o = 1'b0;
		cmd_data_o = ~cmd_data_o;
	endtask : idle
endmodule : ufd_host

//--- bench/user_font_ram_and_display_test_tb.sv
// self-checking bench for the glyph memory and display-test block
// host model issues commands; bench drives oscillator and normal path
module user_font_ram_and_display_test_tb;
	import ufd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i = 1'b0, rst_n_i = 1'b0, osc = 1'b0, cmd_valid_i, rd_valid_o, blink_o;
	logic        test_mode_o, last_blink;
	logic [7:0]  cmd_addr_i, cmd_data_i, rd_data_o, digit_o, glyph_ptr_o, dig_or;
	logic [7:0]  norm_digit_i = 8'h00;
	logic        fast = 1'b1;
	logic [6:0]  raddr = 7'h00, glyph_rdata_o, row_o, norm_row_i = 7'h00;
	logic [6:0]  col [5] = '{7'h42, 7'h61, 7'h51, 7'h49, 7'h46};
	logic [15:0] lit, flips;
	int          n_mismatch = 0, n_checks = 0;
	ufd_host h (.clock_i, .cmd_valid_o(cmd_valid_i), .cmd_addr_o(cmd_addr_i),
		.cmd_data_o(cmd_data_i));
	// small counts keep a full scan frame at 256 clocks
	ufd_glyph_test #(.BLINK_FAST_HALF(8), .BLINK_SLOW_HALF(16), .SLOT_TICKS(16), .ON_TICKS(7)) dut (
		.clock_i, .rst_n_i, .cmd_valid_i, .cmd_addr_i, .cmd_data_i, .rd_valid_o, .rd_data_o,
		.mux_osc_input(osc), .blink_fast_i(fast), .blink_o, .glyph_raddr_i(raddr), .glyph_rdata_o,
		.norm_row_i, .norm_digit_i, .row_o, .digit_o, .test_mode_o, .glyph_ptr_o);
	initial forever #4 clock_i = ~clock_i;
	always @(negedge clock_i) osc <= ~osc;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cmd(input logic [7:0] a, input logic [7:0] d);
		h.acc(a, d);
		@(posedge clock_i);
		#1;
	endtask : cmd
	task automatic settle();
		h.idle();
		repeat (2) @(posedge clock_i);
		#1;
	endtask : settle
	task automatic watch();
		lit = 16'h0000;
		flips = 16'h0000;
		dig_or = 8'h00;
		last_blink = blink_o;
		repeat (256) begin
			@(posedge clock_i) #1;
			if (row_o === 7'h7F) lit++;
			dig_or |= digit_o;
			if (blink_o !== last_blink) flips++;
			last_blink = blink_o;
		end
	endtask : watch
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (16) @(posedge clock_i);
		@(negedge clock_i) rst_n_i = 1'b1;
		norm_row_i = 7'h15;
		norm_digit_i = 8'h03;
		#1 chk({blink_o, test_mode_o, glyph_ptr_o}, {1'b1, 1'b0, UFD_PTR_RST});
		cmd(8'h05, 8'h8A);
		foreach (col[i]) cmd(8'h05, {1'b0, col[i]});
		settle();
		chk(glyph_ptr_o, 8'h8F);
		cmd(8'h05, 8'h8A);
		foreach (col[i]) begin
			cmd(8'h85, 8'h00);
			chk({rd_valid_o, rd_data_o}, {1'b1, 1'b0, col[i]});
		end
		cmd(8'h05, 8'hF7);
		cmd(8'h05, 8'h55);
		settle();
		chk(glyph_ptr_o, 8'h80);
		cmd(8'h05, 8'hF3);
		settle();
		chk(glyph_ptr_o, UFD_GLYPH_LAST);
		cmd(8'h05, 8'hFF);
		settle();
		chk(glyph_ptr_o, 8'h80);
		@(negedge clock_i) raddr = 7'h0A;
		@(posedge clock_i) #1 chk(glyph_rdata_o, col[0]);
		cmd(8'h07, 8'hFE);
		settle();
		chk({test_mode_o, row_o}, {1'b0, 7'h15});
		cmd(8'h07, 8'h01);
		settle();
		watch();
		chk(lit, 16'h0070);
		chk(dig_or, 8'hFF);
		chk(flips, 16'h0010);
		// slow rate doubles the blink phase
		@(negedge clock_i) fast = 1'b0;
		watch();
		chk(lit, 16'h0070);
		chk(flips, 16'h0008);
		cmd(8'h07, 8'h00);
		settle();
		chk({test_mode_o, row_o, digit_o}, {1'b0, 7'h15, 8'h03});
		chk(glyph_ptr_o, 8'h80);
		tally_and_finish();
	end
endmodule : user_font_ram_and_display_test_tb
